// [hdl/dus_serial_status.sv]
// Purpose: serial line status flags with a minimal 8N1 receiver and transmitter
// Assumes: AXI4-Lite register access, one synchronous clock, fixed bit rate
// Notes:   flags set by the line win over a clear in the same cycle
//
// Added by the designer: the AXI4-Lite register port.
module dus_serial_status (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire dus_pkg::dus_axil_req_t bus_req,
   output dus_pkg::dus_axil_rsp_t      bus_rsp,
   input  wire logic                   debug_serial_pin_in,
   output logic                        debug_serial_pin_out,
   output logic                        debug_serial_pin_oe,
   output logic                        irq
);
   typedef struct packed {
      dus_pkg::dus_axil_rsp_t rsp;
      logic                   aw_got;
      logic                   w_got;
      logic [29:0]            widx;
      logic [7:0]             wbyte;
      logic                   wlane;
      logic                   rx_holding_full;
      logic                   rx_overrun_flag;
      logic                   rx_framing_error_flag;
      logic                   rx_break_flag;
      logic                   tx_holding_empty;
      logic                   tx_collision_flag;
      logic [7:0]             rx_data;
      logic [7:0]             tx_holding_register;
      logic                   dbg_owns_pin;
      logic [5:0]             irq_en;
      logic [5:0]             irq_st;
      logic                   irq;
      logic [2:0]             sync;
      logic                   line;
      dus_pkg::dus_rx_st_t    rx_st;
      logic [8:0]             rx_cnt;
      logic [3:0]             rx_bit;
      logic [7:0]             rx_sh;
      logic [3:0]             low_cnt;
      dus_pkg::dus_tx_st_t    tx_st;
      logic [8:0]             tx_cnt;
      logic [3:0]             tx_bit;
      logic [9:0]             tx_sh;
      logic                   pin_out;
      logic                   pin_oe;
   } dus_state_t;

   dus_state_t s;
   dus_state_t next_s;
   logic [5:0] ev;
   logic [5:0] clr;
   logic [7:0] status;
   logic [29:0] ridx;
   logic       sample;
   logic       tx_wr;

   always_comb begin
      next_s = s;
      ev     = '0;
      clr    = '0;
      sample = 1'b0;
      tx_wr  = 1'b0;
      ridx   = bus_req.araddr[31:2];
      status = {s.rx_holding_full, s.rx_overrun_flag, s.rx_framing_error_flag, s.rx_break_flag,
                s.tx_holding_empty, s.tx_collision_flag,
                s.rx_st != dus_pkg::RX_IDLE,
                s.tx_st == dus_pkg::TX_RUN};

      // pin synchroniser, a change counts when stages two and three agree
      next_s.sync = {s.sync[1:0], debug_serial_pin_in};
      if (s.sync[1] == s.sync[2]) begin
         next_s.line = s.sync[2];
      end

      // read channel
      if (s.rsp.rvalid && bus_req.rready) begin
         next_s.rsp.rvalid  = 1'b0;
         next_s.rsp.arready = 1'b1;
      end
      if (bus_req.arvalid && s.rsp.arready) begin
         next_s.rsp.arready = 1'b0;
         next_s.rsp.rvalid  = 1'b1;
         next_s.rsp.rresp   = dus_pkg::RESP_OKAY;
         next_s.rsp.rdata   = 32'h0;
         case (ridx)
            dus_pkg::IDX_STATUS:  next_s.rsp.rdata[7:0] = status;
            dus_pkg::IDX_RX_DATA: begin
               next_s.rsp.rdata[7:0]      = s.rx_data;
               next_s.rx_holding_full     = 1'b0;
            end
            dus_pkg::IDX_TX_HOLD: begin
               next_s.rsp.rdata[7:0]      = s.tx_holding_register;
               next_s.tx_holding_empty    = 1'b1;
            end
            dus_pkg::IDX_CTRL:    next_s.rsp.rdata[dus_pkg::CTRL_DBG_OWN] = s.dbg_owns_pin;
            dus_pkg::IDX_IRQ_ST:  next_s.rsp.rdata[5:0] = s.irq_st;
            dus_pkg::IDX_IRQ_EN:  next_s.rsp.rdata[5:0] = s.irq_en;
            dus_pkg::IDX_IRQ_CLR: next_s.rsp.rdata      = 32'h0;
            default:              next_s.rsp.rresp      = dus_pkg::RESP_DECERR;
         endcase
      end

      // write channels, address and data taken in either order
      if (s.rsp.bvalid && bus_req.bready) begin
         next_s.rsp.bvalid  = 1'b0;
         next_s.rsp.awready = 1'b1;
         next_s.rsp.wready  = 1'b1;
      end
      if (bus_req.awvalid && s.rsp.awready) begin
         next_s.aw_got      = 1'b1;
         next_s.widx        = bus_req.awaddr[31:2];
         next_s.rsp.awready = 1'b0;
      end
      if (bus_req.wvalid && s.rsp.wready) begin
         next_s.w_got      = 1'b1;
         next_s.wbyte      = bus_req.wdata[7:0];
         next_s.wlane      = bus_req.wstrb[0];
         next_s.rsp.wready = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
         next_s.aw_got     = 1'b0;
         next_s.w_got      = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp  = dus_pkg::RESP_OKAY;
         case (s.widx)
            dus_pkg::IDX_STATUS: begin
               if (s.wlane) begin
                  if (s.wbyte[dus_pkg::ST_RX_FULL]) next_s.rx_holding_full = 1'b0;
                  if (s.wbyte[dus_pkg::ST_OVERRUN]) next_s.rx_overrun_flag = 1'b0;
                  if (s.wbyte[dus_pkg::ST_FRAMING]) next_s.rx_framing_error_flag = 1'b0;
                  if (s.wbyte[dus_pkg::ST_BREAK])   next_s.rx_break_flag = 1'b0;
                  if (s.wbyte[dus_pkg::ST_COLL])    next_s.tx_collision_flag = 1'b0;
                  if (s.wbyte[dus_pkg::ST_TX_EMPTY]) next_s.tx_holding_empty = 1'b1;
               end
            end
            dus_pkg::IDX_RX_DATA: begin
               if (s.wlane) begin
                  if (s.rx_holding_full) ev[dus_pkg::EV_OVERRUN] = 1'b1;
                  next_s.rx_data = s.wbyte;
                  ev[dus_pkg::EV_RX_LOAD] = 1'b1;
               end
            end
            dus_pkg::IDX_TX_HOLD: begin
               if (s.wlane) begin
                  next_s.tx_holding_register = s.wbyte;
                  next_s.tx_holding_empty    = 1'b0;
                  tx_wr                      = 1'b1;
               end
            end
            dus_pkg::IDX_CTRL:    if (s.wlane) next_s.dbg_owns_pin = s.wbyte[dus_pkg::CTRL_DBG_OWN];
            dus_pkg::IDX_IRQ_EN:  if (s.wlane) next_s.irq_en = s.wbyte[5:0];
            dus_pkg::IDX_IRQ_CLR: if (s.wlane) clr = s.wbyte[5:0];
            dus_pkg::IDX_IRQ_ST:  next_s.rsp.bresp = dus_pkg::RESP_OKAY;
            default:              next_s.rsp.bresp = dus_pkg::RESP_DECERR;
         endcase
      end
      next_s.rsp.awready = next_s.rsp.awready & ~next_s.aw_got;
      next_s.rsp.wready  = next_s.rsp.wready & ~next_s.w_got;

      // receiver
      case (s.rx_st)
         dus_pkg::RX_IDLE: begin
            // start bit: synced line falls while idle
            if (s.line && !next_s.line) begin
               next_s.rx_st  = dus_pkg::RX_RUN;
               next_s.rx_cnt = dus_pkg::HALF_CNT;
               next_s.rx_bit = 4'h0;
            end
         end
         dus_pkg::RX_RUN: begin
            if (s.rx_cnt == 9'h0) begin
               sample        = 1'b1;
               next_s.rx_cnt = dus_pkg::BIT_CNT;
               next_s.rx_bit = s.rx_bit + 4'h1;
               if (s.rx_bit == 4'h0) begin
                  if (s.line) next_s.rx_st = dus_pkg::RX_IDLE;
               end else if (s.rx_bit < dus_pkg::STOP_BIT) begin
                  next_s.rx_sh = {s.line, s.rx_sh[7:1]};
               end else begin
                  if (s.rx_holding_full) ev[dus_pkg::EV_OVERRUN] = 1'b1;
                  next_s.rx_data          = s.rx_sh;
                  ev[dus_pkg::EV_RX_LOAD] = 1'b1;
                  if (!s.line) begin
                     ev[dus_pkg::EV_FRAMING] = 1'b1;
                     next_s.rx_st = dus_pkg::RX_BRK;
                  end else begin
                     next_s.rx_st = dus_pkg::RX_IDLE;
                  end
               end
            end else begin
               next_s.rx_cnt = s.rx_cnt - 9'h1;
            end
         end
         dus_pkg::RX_BRK: begin
            if (s.line) begin
               next_s.rx_st = dus_pkg::RX_IDLE;
            end else if (s.rx_cnt == 9'h0) begin
               sample        = 1'b1;
               next_s.rx_cnt = dus_pkg::BIT_CNT;
            end else begin
               next_s.rx_cnt = s.rx_cnt - 9'h1;
            end
         end
         default: next_s.rx_st = dus_pkg::RX_IDLE;
      endcase
      if (sample) begin
         if (s.line) begin
            next_s.low_cnt = 4'h0;
         end else if (s.low_cnt != dus_pkg::BREAK_BITS) begin
            next_s.low_cnt = s.low_cnt + 4'h1;
            if (s.low_cnt == dus_pkg::BREAK_BITS - 4'h1) ev[dus_pkg::EV_BREAK] = 1'b1;
         end
      end
      if (next_s.rx_st == dus_pkg::RX_IDLE) next_s.low_cnt = 4'h0;

      // transmitter
      case (s.tx_st)
         dus_pkg::TX_IDLE: begin
            if (!s.tx_holding_empty && !s.dbg_owns_pin) begin
               next_s.tx_st   = dus_pkg::TX_RUN;
               next_s.tx_sh   = {1'b1, s.tx_holding_register, 1'b0};
               next_s.tx_cnt  = dus_pkg::BIT_CNT;
               next_s.tx_bit  = 4'h0;
               next_s.pin_out = 1'b0;
               next_s.pin_oe  = 1'b1;
               ev[dus_pkg::EV_TX_EMPTY] = 1'b1;
            end
         end
         dus_pkg::TX_RUN: begin
            // synced line lags the pin, so compare at mid-bit
            if (s.tx_cnt == dus_pkg::HALF_CNT && s.line != s.pin_out) begin
               ev[dus_pkg::EV_COLL] = 1'b1;
            end
            if (s.tx_cnt == 9'h0) begin
               if (s.tx_bit == dus_pkg::STOP_BIT) begin
                  next_s.tx_st   = dus_pkg::TX_IDLE;
                  next_s.pin_out = 1'b1;
                  next_s.pin_oe  = 1'b0;
               end else begin
                  next_s.tx_bit  = s.tx_bit + 4'h1;
                  next_s.tx_sh   = {1'b1, s.tx_sh[9:1]};
                  next_s.pin_out = s.tx_sh[1];
                  next_s.tx_cnt  = dus_pkg::BIT_CNT;
               end
            end else begin
               next_s.tx_cnt = s.tx_cnt - 9'h1;
            end
         end
         default: next_s.tx_st = dus_pkg::TX_IDLE;
      endcase

      // hardware sets last so they win over software clears
      if (ev[dus_pkg::EV_RX_LOAD])  next_s.rx_holding_full = 1'b1;
      if (ev[dus_pkg::EV_OVERRUN])  next_s.rx_overrun_flag = 1'b1;
      if (ev[dus_pkg::EV_FRAMING])  next_s.rx_framing_error_flag = 1'b1;
      if (ev[dus_pkg::EV_BREAK])    next_s.rx_break_flag = 1'b1;
      // a byte written while the old one moves stays held
      if (ev[dus_pkg::EV_TX_EMPTY] && !tx_wr) next_s.tx_holding_empty = 1'b1;
      if (ev[dus_pkg::EV_COLL])     next_s.tx_collision_flag = 1'b1;
      next_s.irq_st = (s.irq_st & ~clr) | ev;
      next_s.irq    = |(next_s.irq_st & next_s.irq_en);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s <= '0;
         s.rsp.awready         <= 1'b1;
         s.rsp.wready          <= 1'b1;
         s.rsp.arready         <= 1'b1;
         s.tx_holding_empty    <= dus_pkg::STATUS_RST[dus_pkg::ST_TX_EMPTY];
         // line idles high, no false start after reset
         s.sync                <= 3'h7;
         s.line                <= 1'b1;
         s.rx_st               <= dus_pkg::RX_IDLE;
         s.tx_st               <= dus_pkg::TX_IDLE;
         s.pin_out             <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign bus_rsp              = s.rsp;
   assign debug_serial_pin_out = s.pin_out;
   assign debug_serial_pin_oe  = s.pin_oe;
   assign irq                  = s.irq;
endmodule // dus_serial_status

// [hdl/dus_pkg.sv]
// Purpose: constants and carrier types of the serial line status block
// Assumes: 50 MHz mclk, fixed 8N1 framing at a fixed bit rate
// Notes:   register byte address is four times its index
package dus_pkg;
   // bus carriers
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } dus_axil_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dus_axil_rsp_t;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
   // register indices
   localparam logic [29:0] IDX_STATUS  = 30'hffe085;
   localparam logic [29:0] IDX_RX_DATA = 30'hffe088;
   localparam logic [29:0] IDX_TX_HOLD = 30'hffe089;
   localparam logic [29:0] IDX_CTRL    = 30'hffe08a;
   localparam logic [29:0] IDX_IRQ_ST  = 30'hffe08b;
   localparam logic [29:0] IDX_IRQ_EN  = 30'hffe08c;
   localparam logic [29:0] IDX_IRQ_CLR = 30'hffe08d;
   // status bits
   localparam int ST_RX_FULL  = 7;
   localparam int ST_OVERRUN  = 6;
   localparam int ST_FRAMING  = 5;
   localparam int ST_BREAK    = 4;
   localparam int ST_TX_EMPTY = 3;
   localparam int ST_COLL     = 2;
   localparam int ST_RX_ACT   = 1;
   localparam int ST_TX_ACT   = 0;
   localparam logic [7:0] STATUS_RST = 8'h08;
   localparam int CTRL_DBG_OWN = 0;
   // event bits of the interrupt registers
   localparam int EV_W        = 6;
   localparam int EV_RX_LOAD  = 0;
   localparam int EV_OVERRUN  = 1;
   localparam int EV_FRAMING  = 2;
   localparam int EV_BREAK    = 3;
   localparam int EV_TX_EMPTY = 4;
   localparam int EV_COLL     = 5;
   // timing
   localparam int CLK_HZ    = 50_000_000;
   localparam int BAUD_RATE = 115_200;
   localparam logic [8:0] BIT_CNT  = 9'(CLK_HZ / BAUD_RATE - 1);
   localparam logic [8:0] HALF_CNT = 9'(CLK_HZ / BAUD_RATE / 2);
   localparam logic [3:0] BREAK_BITS = 4'ha;
   localparam logic [3:0] STOP_BIT   = 4'h9;
   // states
   typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_RUN = 3'b010, RX_BRK = 3'b100} dus_rx_st_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} dus_tx_st_t;
endpackage

// [tb/dus_far_end.sv]
// Purpose: remote serial device on the shared line
// Assumes: 8N1 at the fixed bit rate, line pulled up when released
// Notes:   drives low or releases only, like an open-drain party
module dus_far_end (
   input  wire logic mclk,
   input  wire logic line,
   output logic      far_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BITP = 434;
   initial far_drive = 1'b1;
   task automatic wait_bits(input int n);
      repeat (n * BITP) @(posedge mclk);
   endtask
   // stop level chosen by caller; low tail extends a break
   task automatic send(input logic [7:0] data, input logic stop, input int low_tail);
      logic [9:0] fr;
      fr = {stop, data, 1'b0};
      @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
         far_drive <= fr[i];
         wait_bits(1);
      end
      if (low_tail > 0) wait_bits(low_tail);
      far_drive <= 1'b1;
      wait_bits(2);
   endtask
   task automatic recv(output logic [7:0] data);
      @(negedge line);
      repeat (BITP / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         wait_bits(1);
         data[i] = line;
      end
   endtask
   // pulls the first data bit low under a sending device
   task automatic collide();
      @(negedge line);
      wait_bits(1);
      far_drive <= 1'b0;
      wait_bits(1);
      far_drive <= 1'b1;
   endtask
endmodule // dus_far_end

// [tb/dus_serial_status_checker.sv]
// Purpose: port assertions of the serial line status block
// Assumes: one clock domain, synchronous reset
// Notes:   bound to every instance of the block
module dus_serial_status_checker (
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire dus_pkg::dus_axil_req_t bus_req,
   input wire dus_pkg::dus_axil_rsp_t bus_rsp,
   input wire logic                   debug_serial_pin_in,
   input wire logic                   debug_serial_pin_out,
   input wire logic                   debug_serial_pin_oe,
   input wire logic                   irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_ar_take;
      bus_req.arvalid && bus_rsp.arready;
   endsequence
   sequence s_st_read;
      s_ar_take ##0 bus_req.araddr == {dus_pkg::IDX_STATUS, 2'b00} && debug_serial_pin_oe == $past(debug_serial_pin_oe);
   endsequence
   a_read_answer: assert property (s_ar_take |=> bus_rsp.rvalid && !bus_rsp.arready)
      else $error("read not answered");
   a_rdata_hold: assert property (bus_rsp.rvalid && !bus_req.rready |=> bus_rsp.rvalid && $stable(bus_rsp.rdata))
      else $error("read data left early");
   a_bresp_hold: assert property (bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid)
      else $error("write response left early");
   a_write_answer: assert property (bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready
      |-> ##2 bus_rsp.bvalid) else $error("write not answered");
   a_unmapped_decerr: assert property (s_ar_take ##0 bus_req.araddr[31:8] != 24'h03ff82
      |=> bus_rsp.rresp == dus_pkg::RESP_DECERR && bus_rsp.rdata == 32'h0) else $error("unmapped read not refused");
   a_idle_high: assert property (!debug_serial_pin_oe |-> debug_serial_pin_out)
      else $error("line not idle high");
   a_start_low: assert property ($rose(debug_serial_pin_oe) |-> (debug_serial_pin_oe && !debug_serial_pin_out)[*8])
      else $error("frame start not low");
   a_tx_busy_bit: assert property (s_st_read ##1 debug_serial_pin_oe == $past(debug_serial_pin_oe)
      |-> bus_rsp.rdata[dus_pkg::ST_TX_ACT] == debug_serial_pin_oe) else $error("busy bit differs from line drive");
endmodule // dus_serial_status_checker
bind dus_serial_status dus_serial_status_checker u_chk (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
   .debug_serial_pin_in(debug_serial_pin_in), .debug_serial_pin_out(debug_serial_pin_out),
   .debug_serial_pin_oe(debug_serial_pin_oe), .irq(irq));

// [tb/tb.sv]
// Purpose: self-checking bench of the serial line status block
// Assumes: 50 MHz mclk, wired-and line with pull-up
// Notes:   bus results are queued by the drivers and checked by a monitor
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_ST = {dus_pkg::IDX_STATUS, 2'b00};
   localparam logic [31:0] A_RX = {dus_pkg::IDX_RX_DATA, 2'b00};
   localparam logic [31:0] A_TX = {dus_pkg::IDX_TX_HOLD, 2'b00};
   localparam logic [31:0] A_CT = {dus_pkg::IDX_CTRL, 2'b00};
   localparam logic [31:0] A_IE = {dus_pkg::IDX_IRQ_EN, 2'b00};
   localparam logic [31:0] A_IC = {dus_pkg::IDX_IRQ_CLR, 2'b00};
   logic                   mclk = 1'b0;
   logic                   rst = 1'b1;
   dus_pkg::dus_axil_req_t req = '0;
   dus_pkg::dus_axil_rsp_t rsp;
   logic                   pin_out, pin_oe, irq, far_drive, line;
   logic [33:0]            q_exp[$], q_mask[$];
   logic [7:0]             b, got;
   int                     num_errors = 0, n_tests = 0, cycles = 0;
   always #10 mclk = ~mclk;
   assign line = far_drive & (pin_oe ? pin_out : 1'b1);
   dus_serial_status DUT (.mclk(mclk), .rst(rst), .bus_req(req), .bus_rsp(rsp), .debug_serial_pin_in(line),
      .debug_serial_pin_out(pin_out), .debug_serial_pin_oe(pin_oe), .irq(irq));
   dus_far_end u_far (.mclk(mclk), .line(line), .far_drive(far_drive));
   task automatic check(input string name, input logic [33:0] exp, input logic [33:0] seen);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 70000) begin
         num_errors++;
         $display("mismatch run length expected end seen hang");
         final_report();
      end
      if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
         if (q_exp.size() == 0) check("bus result", '1, '0);
         else check("bus result", q_exp.pop_front(),
                    (rsp.rvalid ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h0}) & q_mask.pop_front());
      end
   end
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] resp = dus_pkg::RESP_OKAY);
      q_exp.push_back({resp, 32'h0});
      q_mask.push_back({2'h3, 32'h0});
      req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
      req.wdata <= {24'h0, d}; req.wstrb <= 4'h1; req.bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e,
                     input logic [1:0] resp = dus_pkg::RESP_OKAY);
      q_exp.push_back({resp, 24'h0, e & m});
      q_mask.push_back({2'h3, 24'hffffff, m});
      req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
   endtask
   task automatic chk_irq(input logic e);
      repeat (2) @(posedge mclk);
      check("irq", {33'h0, e}, {33'h0, irq});
   endtask
   initial begin
      void'($urandom(1));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(A_ST, 8'hff, dus_pkg::STATUS_RST);
      b = 8'($urandom());
      wr(A_IE, 8'h01);
      wr(A_RX, 8'h5a);
      rd(A_ST, 8'hc0, 8'h80);
      chk_irq(1'b1);
      wr(A_RX, b);
      rd(A_ST, 8'hc0, 8'hc0);
      rd(A_RX, 8'hff, b);
      rd(A_ST, 8'hc0, 8'h40);
      wr(A_ST, 8'h40);
      wr(A_RX, b);
      wr(A_ST, 8'h00);
      rd(A_ST, 8'hc0, 8'h80);
      wr(A_ST, 8'h80);
      rd(A_ST, 8'hc0, 8'h00);
      wr(A_IE, 8'h00);
      chk_irq(1'b0);
      wr(A_IE, 8'h01);
      wr(A_IC, 8'h3f);
      chk_irq(1'b0);
      $display("flag tests done");
      wr(A_CT, 8'h01);
      wr(A_TX, b);
      rd(A_ST, 8'h08, 8'h00);
      rd(A_TX, 8'hff, b);
      rd(A_ST, 8'h08, 8'h08);
      wr(A_TX, ~b);
      wr(A_ST, 8'h08);
      rd(A_ST, 8'h08, 8'h08);
      wr(A_CT, 8'h00);
      repeat (3) @(posedge mclk);
      check("line drive", 34'h0, {33'h0, pin_oe});
      b = 8'($urandom());
      fork
         u_far.recv(got);
         begin
            wr(A_TX, b);
            rd(A_ST, 8'h09, 8'h09);
         end
      join
      check("line byte", {26'h0, b}, {26'h0, got});
      wait (!pin_oe);
      @(posedge mclk);
      rd(A_ST, 8'h01, 8'h00);
      $display("transmit tests done");
      wr(A_ST, 8'hf4);
      fork
         u_far.send(b, 1'b1, 0);
         begin
            u_far.wait_bits(2);
            rd(A_ST, 8'h02, 8'h02);
         end
      join
      rd(A_ST, 8'hf2, 8'h80);
      rd(A_RX, 8'hff, b);
      u_far.send(8'h55, 1'b0, 0);
      rd(A_ST, 8'hf0, 8'ha0);
      wr(A_ST, 8'h20);
      rd(A_ST, 8'h20, 8'h00);
      u_far.send(8'h00, 1'b0, 2);
      rd(A_ST, 8'h10, 8'h10);
      wr(A_ST, 8'hf0);
      rd(A_ST, 8'hf0, 8'h00);
      $display("receive tests done");
      fork
         u_far.collide();
         wr(A_TX, 8'hff);
      join
      wait (!pin_oe);
      rd(A_ST, 8'h04, 8'h04);
      wr(A_ST, 8'hfb);
      rd(A_ST, 8'h04, 8'h04);
      wr(A_ST, 8'h04);
      rd(A_ST, 8'h04, 8'h00);
      rd(32'h10, 8'hff, 8'h00, dus_pkg::RESP_DECERR);
      wr(32'h10, 8'h01, dus_pkg::RESP_DECERR);
      $display("collision and map tests done");
      final_report();
   end
endmodule // tb
